// ---- hdl/ssc_regs.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ssc_defs.svh"

module ssc_act_mon #(
  parameter int LIMIT = 10000
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output var  logic act_o,
  output var  logic pol_o,
  output var  logic lead_o
);
  logic [15:0] run_q;
  logic [15:0] hi_len_q;
  logic [15:0] lo_len_q;
  logic        prev_q;
  wire         toggle = d_i ^ prev_q;
  wire         quiet  = run_q >= 16'(LIMIT);

  // Run length doubles as the quiet timer and the level-width meter.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q   <= 1'b0;
      run_q    <= 16'hFFFF;
      hi_len_q <= 16'h0000;
      lo_len_q <= 16'h0000;
      act_o    <= 1'b0;
      pol_o    <= 1'b0;
      lead_o   <= 1'b0;
    end else begin
      prev_q <= d_i;
      lead_o <= toggle & (d_i == pol_o);
      act_o  <= toggle | ~quiet;
      pol_o  <= hi_len_q < lo_len_q;
      if (toggle) begin
        run_q <= 16'h0000;
        if (prev_q) begin
          hi_len_q <= run_q;
        end else begin
          lo_len_q <= run_q;
        end
      end else if (run_q != 16'hFFFF) begin
        run_q <= run_q + 16'h0001;
      end
    end
  end

  property p_act_on;
    @(posedge clk_i) disable iff (rst_i) toggle |=> act_o;
  endproperty
  a_act_on: assert property (p_act_on) else $error("toggle not seen as activity");

  property p_act_off;
    @(posedge clk_i) disable iff (rst_i) (quiet && !toggle) |=> !act_o;
  endproperty
  a_act_off: assert property (p_act_off) else $error("quiet input still active");
endmodule // ssc_act_mon

module ssc_regs
  import ssc_pkg::*;
#(
  parameter int ACT_WINDOW_CYC = `SSC_ACT_WINDOW_CYC
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output var  logic [31:0]  wb_dat_o,
  output var  logic         wb_ack_o,
  input  wire ssc_sync_in_t sync_i,
  input  wire logic         ext_clock_or_coast_pin_i,
  input  wire logic         ext_clamp_i,
  output var  logic         proc_sync_o,
  output var  logic         regen_sync_o,
  output var  logic         green_sync_filt_o,
  output var  logic         vco_low_gear_o,
  output var  logic         offset_update_o,
  output var  logic         gain_update_o
);
  logic [7:0] ctrl_q, rsv_a_q, rsv_b_q, win_q, test1_q, test2_q;
  logic [7:0] off_hold_q, test5_q, test6_q, src_q, auto_q, upd_int_q;
  logic [7:0] gf_ctrl_q, vco_q, gain_q;
  logic [7:0] act_w, pol_w, lead_w;

  // Bus slave: one wait state, write lands on the acknowledging edge.
  wire [5:0] idx   = wb_adr_i[7:2];
  wire       req   = wb_cyc_i & wb_stb_i;
  wire       wr_en = req & wb_we_i & wb_ack_o & wb_sel_i[0];
  wire [7:0] wdat  = wb_dat_i[7:0];

  // Monitors: bits 7..2 are the six syncs, then coast, then clamp.
  wire [7:0] mon_in = {sync_i, ext_clock_or_coast_pin_i, ext_clamp_i};
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_mon
      ssc_act_mon #(.LIMIT(ACT_WINDOW_CYC)) u_mon (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .d_i    (mon_in[gi]),
        .act_o  (act_w[gi]),
        .pol_o  (pol_w[gi]),
        .lead_o (lead_w[gi])
      );
    end
  endgenerate

  // Green sync pulse filter on the selected green input.
  logic [1:0] gf_cnt_q;
  logic       gf_prev_q;
  wire        green_raw = src_q[0] ? sync_i.green_sync_in_b : sync_i.green_sync_in_a;
  wire        gf_en     = gf_ctrl_q[`SSC_GF_EN_BIT];
  wire        gf_long   = gf_cnt_q == 2'(`SSC_GF_MIN_CYC - 1);
  wire        green_lead = gf_prev_q & ~green_sync_filt_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gf_cnt_q          <= 2'h0;
      gf_prev_q         <= 1'b0;
      green_sync_filt_o <= 1'b0;
    end else begin
      gf_prev_q <= green_sync_filt_o;
      gf_cnt_q  <= (green_raw && !gf_long) ? gf_cnt_q + 2'h1 : (green_raw ? gf_cnt_q : 2'h0);
      green_sync_filt_o <= green_raw & (~gf_en | gf_long);
    end
  end

  // Horizontal sync filter and regenerator.
  ssc_filt_state_t st_q;
  logic [15:0] ph_q, per_q;
  logic [1:0]  lk_q;
  logic        extr_q, extr_line_q;
  wire         hs_lead = src_q[1] ? green_lead : (src_q[0] ? lead_w[6] : lead_w[7]);
  wire  [16:0] win_cyc = 17'((18'(win_q) * `SSC_WIN_STEP_NS) / `SSC_CLK_PERIOD_NS);
  wire  [16:0] ph_ext  = {1'b0, ph_q};
  wire  [16:0] per_ext = {1'b0, per_q};
  wire         in_win  = (ph_ext + win_cyc >= per_ext) && (ph_ext <= per_ext + win_cyc);
  wire         late    = ph_ext > per_ext + win_cyc;
  wire         accept  = hs_lead && (st_q == SF_HUNT || in_win);
  wire         reject  = hs_lead && !accept;
  wire         locked  = st_q == SF_LOCK;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q         <= SF_HUNT;
      ph_q         <= 16'h0000;
      per_q        <= 16'h0000;
      lk_q         <= 2'h0;
      extr_q       <= 1'b0;
      extr_line_q  <= 1'b0;
      regen_sync_o <= 1'b0;
    end else begin
      regen_sync_o <= accept;
      if (ph_q != 16'hFFFF) begin
        ph_q <= ph_q + 16'h0001;
      end
      if (accept) begin
        ph_q        <= 16'h0000;
        per_q       <= ph_q;
        extr_q      <= extr_line_q;
        extr_line_q <= 1'b0;
        if (!in_win) begin
          lk_q <= 2'h0;
        end else if (lk_q == `SSC_LOCK_EDGES) begin
          st_q <= SF_LOCK;
        end else begin
          lk_q <= lk_q + 2'h1;
        end
      end else if (reject) begin
        extr_line_q <= 1'b1;
      end else if (st_q == SF_LOCK && late) begin
        st_q <= SF_HUNT;
        lk_q <= 2'h0;
      end
    end
  end

  // Sync processing source, line counter and calibration update ticks.
  logic [11:0] hcnt_q, lines_q;
  logic [7:0]  upd_cnt_q;
  logic [3:0]  off_set_q, gain_set_q;
  logic        tick_q;
  wire vs_lead    = src_q[0] ? lead_w[4] : lead_w[5];
  wire src_pick   = ctrl_q[`SSC_CTRL_SRC_BIT] ? regen_sync_o : hs_lead;
  wire off_run    = auto_q[0] & ~off_hold_q[`SSC_OFF_HOLD_BIT];
  wire gain_run   = gain_q[`SSC_GAIN_HOLD_BIT] & (gain_q[2:0] == `SSC_GAIN_ON);
  wire off_done   = off_set_q == `SSC_SETTLE_UPDATES;
  wire gain_done  = gain_set_q == `SSC_SETTLE_UPDATES;
  wire upd_wrap   = proc_sync_o && (upd_cnt_q + 8'h01 >= upd_int_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      proc_sync_o     <= 1'b0;
      hcnt_q          <= 12'h000;
      lines_q         <= 12'h000;
      upd_cnt_q       <= 8'h00;
      tick_q          <= 1'b0;
      off_set_q       <= 4'h0;
      gain_set_q      <= 4'h0;
      offset_update_o <= 1'b0;
      gain_update_o   <= 1'b0;
    end else begin
      proc_sync_o <= src_pick;
      if (vs_lead) begin
        lines_q <= hcnt_q;
        hcnt_q  <= {11'h000, proc_sync_o};
      end else if (proc_sync_o && hcnt_q != 12'hFFF) begin
        hcnt_q <= hcnt_q + 12'h001;
      end
      tick_q    <= upd_wrap;
      upd_cnt_q <= upd_wrap ? 8'h00 : (proc_sync_o ? upd_cnt_q + 8'h01 : upd_cnt_q);
      offset_update_o <= tick_q & off_run;
      gain_update_o   <= tick_q & gain_run;
      if (!off_run) begin
        off_set_q <= 4'h0;
      end else if (tick_q && !off_done) begin
        off_set_q <= off_set_q + 4'h1;
      end
      if (!gain_run) begin
        gain_set_q <= 4'h0;
      end else if (tick_q && !gain_done) begin
        gain_set_q <= gain_set_q + 4'h1;
      end
    end
  end

  // Writable registers; the two read-only test locations have no storage.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q     <= `SSC_RST_CTRL;
      rsv_a_q    <= `SSC_RST_RSV;
      rsv_b_q    <= `SSC_RST_RSV;
      win_q      <= `SSC_RST_WIN;
      test1_q    <= `SSC_RST_ZERO;
      test2_q    <= `SSC_RST_ZERO;
      off_hold_q <= `SSC_RST_ZERO;
      test5_q    <= `SSC_RST_ZERO;
      test6_q    <= `SSC_RST_ZERO;
      src_q      <= `SSC_RST_ZERO;
      auto_q     <= `SSC_RST_ZERO;
      upd_int_q  <= `SSC_RST_UPD_INT;
      gf_ctrl_q  <= `SSC_RST_ZERO;
      vco_q      <= `SSC_RST_ZERO;
      gain_q     <= `SSC_RST_ZERO;
    end else if (wr_en) begin
      if (idx == `SSC_IDX_CTRL) ctrl_q <= wdat;
      if (idx == `SSC_IDX_RSV_A) rsv_a_q <= wdat;
      if (idx == `SSC_IDX_RSV_B) rsv_b_q <= wdat;
      if (idx == `SSC_IDX_WIN) win_q <= wdat;
      if (idx == `SSC_IDX_TEST1) test1_q <= wdat;
      if (idx == `SSC_IDX_TEST2) test2_q <= wdat;
      if (idx == `SSC_IDX_OFF_HOLD) off_hold_q <= wdat;
      if (idx == `SSC_IDX_TEST5) test5_q <= wdat;
      if (idx == `SSC_IDX_TEST6) test6_q <= wdat;
      if (idx == `SSC_IDX_SRC_SEL) src_q <= wdat;
      if (idx == `SSC_IDX_AUTO_CTRL) auto_q <= wdat;
      if (idx == `SSC_IDX_UPD_INT) upd_int_q <= wdat;
      if (idx == `SSC_IDX_GF_CTRL) gf_ctrl_q <= wdat;
      if (idx == `SSC_IDX_VCO) vco_q <= wdat;
      if (idx == `SSC_IDX_GAIN) gain_q <= wdat;
    end
  end

  assign vco_low_gear_o = vco_q[0];

  // Read selection; unmapped and read-only test locations read zero.
  wire [7:0] act_stat = act_w;
  wire [7:0] pol_stat = {pol_w[7:4], pol_w[1:0], extr_q, st_q == SF_LOCK};
  wire [7:0] rd_mux =
    (idx == `SSC_IDX_CTRL)      ? ctrl_q :
    (idx == `SSC_IDX_RSV_A)     ? rsv_a_q :
    (idx == `SSC_IDX_RSV_B)     ? rsv_b_q :
    (idx == `SSC_IDX_WIN)       ? win_q :
    (idx == `SSC_IDX_ACT)       ? act_stat :
    (idx == `SSC_IDX_POL)       ? pol_stat :
    (idx == `SSC_IDX_CNT_HI)    ? lines_q[11:4] :
    (idx == `SSC_IDX_CNT_LO)    ? {lines_q[3:0], 4'h0} :
    (idx == `SSC_IDX_TEST1)     ? test1_q :
    (idx == `SSC_IDX_TEST2)     ? test2_q :
    (idx == `SSC_IDX_OFF_HOLD)  ? off_hold_q :
    (idx == `SSC_IDX_TEST5)     ? test5_q :
    (idx == `SSC_IDX_TEST6)     ? test6_q :
    (idx == `SSC_IDX_SRC_SEL)   ? src_q :
    (idx == `SSC_IDX_AUTO_CTRL) ? auto_q :
    (idx == `SSC_IDX_UPD_INT)   ? upd_int_q :
    (idx == `SSC_IDX_CAL_STAT)  ? {6'h00, gain_done, off_done} :
    (idx == `SSC_IDX_GF_CTRL)   ? gf_ctrl_q :
    (idx == `SSC_IDX_VCO)       ? vco_q :
    (idx == `SSC_IDX_GAIN)      ? gain_q : 8'h00;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      wb_dat_o <= {24'h000000, rd_mux};
    end
  end

  // Checks.
  sequence s_read_of(logic [5:0] a);
    req && !wb_we_i && !wb_ack_o && idx == a ##1 wb_ack_o;
  endsequence

  property p_src_sel;
    @(posedge clk_i) disable iff (rst_i)
      proc_sync_o == $past(src_pick);
  endproperty
  a_src_sel: assert property (p_src_sel) else $error("wrong sync processing source");

  property p_reject;
    @(posedge clk_i) disable iff (rst_i) first_match(reject ##[1:40] accept) |=> extr_q;
  endproperty
  a_reject: assert property (p_reject) else $error("rejected pulse not flagged");

  property p_lock_read;
    @(posedge clk_i) disable iff (rst_i)
      s_read_of(`SSC_IDX_POL) |-> wb_dat_o[0] == $past(locked);
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock bit misreported");

  property p_ro_test;
    @(posedge clk_i) disable iff (rst_i)
      s_read_of(`SSC_IDX_TEST3) |-> wb_dat_o == 32'h0000_0000;
  endproperty
  a_ro_test: assert property (p_ro_test) else $error("read-only test location not zero");

  property p_line_latch;
    @(posedge clk_i) disable iff (rst_i) vs_lead |=> lines_q == $past(hcnt_q);
  endproperty
  a_line_latch: assert property (p_line_latch) else $error("line count not latched");

  property p_off_hold;
    @(posedge clk_i) disable iff (rst_i)
      off_hold_q[`SSC_OFF_HOLD_BIT] [*2] |-> !offset_update_o;
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("offset updated while held");

  property p_gain_run;
    @(posedge clk_i) disable iff (rst_i) gain_update_o |-> $past(gain_run);
  endproperty
  a_gain_run: assert property (p_gain_run) else $error("gain updated while frozen");

  property p_green_filt;
    @(posedge clk_i) disable iff (rst_i)
      $rose(green_sync_filt_o) && $past(gf_en) |-> $past(green_raw, 2) && $past(green_raw, 3);
  endproperty
  a_green_filt: assert property (p_green_filt) else $error("narrow green pulse passed");

  property p_settle;
    @(posedge clk_i) disable iff (rst_i) off_set_q <= `SSC_SETTLE_UPDATES;
  endproperty
  a_settle: assert property (p_settle) else $error("settle count overran");
endmodule // ssc_regs
`default_nettype wire

// ---- include/ssc_defs.svh ----
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH
`define SSC_IDX_CTRL        6'h20
`define SSC_IDX_RSV_A       6'h21
`define SSC_IDX_RSV_B       6'h22
`define SSC_IDX_WIN         6'h23
`define SSC_IDX_ACT         6'h24
`define SSC_IDX_POL         6'h25
`define SSC_IDX_CNT_HI      6'h26
`define SSC_IDX_CNT_LO      6'h27
`define SSC_IDX_TEST1       6'h28
`define SSC_IDX_TEST2       6'h29
`define SSC_IDX_TEST3       6'h2A
`define SSC_IDX_TEST4       6'h2B
`define SSC_IDX_OFF_HOLD    6'h2C
`define SSC_IDX_TEST5       6'h2D
`define SSC_IDX_TEST6       6'h2E
`define SSC_IDX_SRC_SEL     6'h30
`define SSC_IDX_AUTO_CTRL   6'h31
`define SSC_IDX_UPD_INT     6'h32
`define SSC_IDX_CAL_STAT    6'h33
`define SSC_IDX_GF_CTRL     6'h34
`define SSC_IDX_VCO         6'h36
`define SSC_IDX_GAIN        6'h3C
`define SSC_CTRL_SRC_BIT    1
`define SSC_OFF_HOLD_BIT    4
`define SSC_GF_EN_BIT       2
`define SSC_GAIN_HOLD_BIT   3
`define SSC_GAIN_ON         3'h6
`define SSC_RST_CTRL        8'h08
`define SSC_RST_RSV         8'h00
`define SSC_RST_WIN         8'h0A
`define SSC_RST_ZERO        8'h00
`define SSC_RST_UPD_INT     8'h40
`define SSC_CLK_PERIOD_NS   100
`define SSC_WIN_STEP_NS     25
`define SSC_GF_MIN_NS       250
`define SSC_GF_MIN_CYC      ((`SSC_GF_MIN_NS + `SSC_CLK_PERIOD_NS - 1) / `SSC_CLK_PERIOD_NS)
`define SSC_ACT_WINDOW_NS   1000000
`define SSC_ACT_WINDOW_CYC  (`SSC_ACT_WINDOW_NS / `SSC_CLK_PERIOD_NS)
`define SSC_SETTLE_UPDATES  4'hA
`define SSC_LOCK_EDGES      2'h3
`endif

// ---- include/ssc_pkg.sv ----
package ssc_pkg;
  typedef struct packed {
    logic horiz_sync_in_a;
    logic horiz_sync_in_b;
    logic vert_sync_in_a;
    logic vert_sync_in_b;
    logic green_sync_in_a;
    logic green_sync_in_b;
  } ssc_sync_in_t;
  typedef enum logic [0:0] {
    SF_HUNT = 1'b0,
    SF_LOCK = 1'b1
  } ssc_filt_state_t;
endpackage

// ---- tb/ssc_regs_test.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ssc_defs.svh"
module ssc_regs_test;
  import ssc_pkg::*;
  logic         clk_i, rst_i, cyc, stb, we, en, h_prev, g_seen;
  logic [7:0]   adr, rd;
  logic [3:0]   sel;
  logic [31:0]  wdat, dat_o;
  logic         ack, proc_s, regen_s, green_f, vco, offs_u, gain_u, coast, clamp;
  ssc_sync_in_t sync;
  int           err_count, compares, offs_n, gain_n, since, last_d, d0, k, reg_d;
  int           seed = 32'h31c70f76;
  logic [5:0]   rw_idx [7] = '{6'h21, 6'h22, 6'h23, 6'h28, 6'h29, 6'h2D, 6'h2E};
  ssc_regs #(.ACT_WINDOW_CYC(200)) ssc_regs_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .sync_i(sync), .ext_clock_or_coast_pin_i(coast), .ext_clamp_i(clamp),
    .proc_sync_o(proc_s), .regen_sync_o(regen_s), .green_sync_filt_o(green_f),
    .vco_low_gear_o(vco), .offset_update_o(offs_u), .gain_update_o(gain_u));
  ssc_sync_src ssc_sync_src_i (
    .clk_i(clk_i), .en_i(en), .sync_o(sync), .coast_o(coast), .clamp_o(clamp));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    #(100 * 40000);
    err_count++;
    finish_test();
  end
  always @(posedge clk_i) begin
    if (offs_u === 1'b1) offs_n++;
    if (gain_u === 1'b1) gain_n++;
    if (green_f === 1'b1) g_seen = 1'b1;
    since  = (sync.horiz_sync_in_a && !h_prev) ? 0 : since + 1;
    h_prev = sync.horiz_sync_in_a;
    if (proc_s === 1'b1) last_d = since;
    if (regen_s === 1'b1) reg_d = since;
  end
  task finish_test;
    $display("Checks made: %0d, mismatches: %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One classic cycle: the request is held until ack is sampled high.
  task wb(input logic w, input logic [5:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'h0};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd  = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask
  task rchk(input string name, input logic [5:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    chk(name, exp, rd);
  endtask
  task run(input logic [5:0] idx, input logic [7:0] d, input int cyc_n);
    wb(1'b1, idx, d);
    repeat (4) @(posedge clk_i);
    offs_n = 0;
    gain_n = 0;
    repeat (cyc_n) @(posedge clk_i);
  endtask
  initial begin
    {cyc, stb, we, en, h_prev, g_seen} = '0;
    {adr, wdat, since, last_d} = '0;
    sel   = 4'hF;
    rst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk("ctrl_rst", `SSC_IDX_CTRL, 8'h08);
    rchk("win_rst", `SSC_IDX_WIN, 8'h0A);
    rchk("gfilt_rst", `SSC_IDX_GF_CTRL, 8'h00);
    rchk("gain_rst", `SSC_IDX_GAIN, 8'h00);
    rchk("act_rst", `SSC_IDX_ACT, 8'h00);
    for (k = 0; k < 7; k++) begin
      d0 = $random(seed);
      wb(1'b1, rw_idx[k], d0[7:0]);
      rchk("rw_reg", rw_idx[k], d0[7:0]);
    end
    for (k = 0; k < 3; k++) begin
      wb(1'b1, (k == 2) ? 6'h3F : 6'h2A + k[5:0], 8'hA5);
      rchk("ro_reg", (k == 2) ? 6'h3F : 6'h2A + k[5:0], 8'h00);
    end
    wb(1'b1, `SSC_IDX_CTRL, 8'h0B);
    wb(1'b1, `SSC_IDX_TEST1, 8'hBF);
    wb(1'b1, `SSC_IDX_TEST2, 8'h02);
    wb(1'b1, `SSC_IDX_TEST5, 8'hE8);
    wb(1'b1, `SSC_IDX_TEST6, 8'hE0);
    wb(1'b1, `SSC_IDX_WIN, 8'h0A);
    wb(1'b1, `SSC_IDX_OFF_HOLD, 8'h00);
    rchk("test1", `SSC_IDX_TEST1, 8'hBF);
    en <= 1'b1;
    repeat (700) @(posedge clk_i);
    rchk("activity", `SSC_IDX_ACT, 8'hA3);
    rchk("polarity", `SSC_IDX_POL, 8'hA9);
    rchk("count_hi", `SSC_IDX_CNT_HI, 8'h00);
    rchk("count_lo", `SSC_IDX_CNT_LO, 8'h80);
    ssc_sync_src_i.extra_pulse();
    repeat (12) @(posedge clk_i);
    rchk("extraneous", `SSC_IDX_POL, 8'hAB);
    run(`SSC_IDX_CTRL, 8'h09, 100);
    d0 = last_d;
    run(`SSC_IDX_CTRL, 8'h0B, 100);
    chk("regen_delay", d0[7:0] + 8'h01, last_d[7:0]);
    chk("regen_pulse", d0[7:0], reg_d[7:0]);
    wb(1'b1, `SSC_IDX_UPD_INT, 8'h01);
    wb(1'b1, `SSC_IDX_AUTO_CTRL, 8'h01);
    run(`SSC_IDX_GAIN, 8'h0E, 224);
    chk("offset_run", 8'h01, {7'h0, offs_n > 0});
    rchk("settled", `SSC_IDX_CAL_STAT, 8'h03);
    run(`SSC_IDX_OFF_HOLD, 8'h10, 150);
    chk("offset_hold", 8'h00, offs_n[7:0]);
    for (k = 0; k < 8; k++) begin
      run(`SSC_IDX_GAIN, {5'h01, k[2:0]}, 100);
      chk("gain_field", {7'h0, k == 6}, {7'h0, gain_n > 0});
    end
    run(`SSC_IDX_GAIN, 8'h06, 150);
    chk("gain_frozen", 8'h00, gain_n[7:0]);
    for (k = 0; k < 3; k++) begin
      wb(1'b1, `SSC_IDX_GF_CTRL, (k == 0) ? 8'h00 : 8'h04);
      repeat (8) @(posedge clk_i);
      g_seen = 1'b0;
      ssc_sync_src_i.green_pulse((k == 2) ? 5 : 2);
      repeat (10) @(posedge clk_i);
      chk("green_pass", {7'h0, k != 1}, {7'h0, g_seen});
    end
    wb(1'b1, `SSC_IDX_VCO, 8'h01);
    @(posedge clk_i);
    chk("vco_low", 8'h01, {7'h0, vco});
    wb(1'b1, `SSC_IDX_VCO, 8'h00);
    @(posedge clk_i);
    chk("vco_norm", 8'h00, {7'h0, vco});
    en <= 1'b0;
    repeat (250) @(posedge clk_i);
    rchk("act_quiet", `SSC_IDX_ACT, 8'h00);
    finish_test();
  end
endmodule // ssc_regs_test
`default_nettype wire

// ---- tb/ssc_sync_src.sv ----
`timescale 1ns/1ns
`default_nettype none
module ssc_sync_src
  import ssc_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          en_i,
  output var  ssc_sync_in_t  sync_o,
  output var  logic          coast_o,
  output var  logic          clamp_o
);
  logic [3:0] pos_q;
  logic [2:0] line_q;
  logic       green_q;
  logic       extra_q;
  initial green_q = 1'b0;
  initial extra_q = 1'b0;
  // Sixteen-cycle lines and eight lines a frame; a stopped source holds every line low except green_sync_in_a, which green_pulse still drives.
  always_ff @(posedge clk_i) begin
    pos_q  <= en_i ? pos_q + 4'h1 : 4'h0;
    line_q <= en_i ? line_q + {2'h0, pos_q == 4'hF} : 3'h0;
  end
  always_comb begin
    sync_o                 = '0;
    sync_o.horiz_sync_in_a = (en_i && (pos_q < 4'h2)) || extra_q;
    sync_o.vert_sync_in_a  = en_i && (line_q == 3'h0) && (pos_q[3:2] == 2'h2);
    sync_o.green_sync_in_a = green_q;
  end
  assign coast_o = en_i && (pos_q[2:0] < 3'h3);
  assign clamp_o = en_i && (pos_q[2:0] < 3'h6);
  task green_pulse(input int w);
    @(posedge clk_i);
    green_q <= 1'b1;
    repeat (w) @(posedge clk_i);
    green_q <= 1'b0;
  endtask
  // One stray pulse in mid-line, far outside the window around the next edge.
  task extra_pulse;
    @(posedge clk_i);
    while (pos_q != 4'h6) @(posedge clk_i);
    extra_q <= 1'b1;
    repeat (2) @(posedge clk_i);
    extra_q <= 1'b0;
  endtask
endmodule // ssc_sync_src
`default_nettype wire
